// File: hdl/cbs_defs.svh
// register offsets, field positions, revision value and timing counts
`ifndef CBS_DEFS_SVH
`define CBS_DEFS_SVH
`define CBS_CLK_MHZ 100
`define CBS_POR_DELAY_NS 1000
`define CBS_POR_CYCLES (((`CBS_POR_DELAY_NS * `CBS_CLK_MHZ) + 999) / 1000)
`define CBS_SYNC_HOLD_NS 100
`define CBS_SYNC_CYCLES (((`CBS_SYNC_HOLD_NS * `CBS_CLK_MHZ) + 999) / 1000)
`define CBS_NUM_CH 5
`define CBS_NV_WORDS 8
`define CBS_ADDR_LAST_CH 4'h4
`define CBS_ADDR_INPUT 4'h5
`define CBS_ADDR_TERM2 4'h6
`define CBS_ADDR_CTRL 4'h8
`define CBS_CTRL_SLEEP 7
`define CBS_CTRL_SYNC 8
`define CBS_CTRL_REV_LSB 10
`define CBS_REV_VALUE 3'h1
`define CBS_IN_FMT_Y 0
`define CBS_IN_FMT_X 1
`define CBS_IN_DC 6
`define CBS_IN_HYST 7
`define CBS_IN_PRI_TERM_OFF 8
`define CBS_IN_FAILSAFE 11
`define CBS_SEC_TERM_OFF 12
`define CBS_CH_SRC_X 4
`define CBS_CH_SRC_Y 5
`define CBS_CH_DRV_LSB 22
`endif

// File: hdl/cbs_pkg.sv
// types shared by the state control and channel decode
package cbs_pkg;
  typedef enum logic [2:0] {
    ST_POR = 3'b000,
    ST_LOAD = 3'b001,
    ST_SYNC = 3'b010,
    ST_ACTIVE = 3'b011,
    ST_PDOWN = 3'b100,
    ST_SLEEP = 3'b101
  } cbs_state_e;
  typedef enum logic [1:0] {
    IN_CMOS = 2'b00,
    IN_PECL = 2'b01,
    IN_LVDS = 2'b10,
    IN_OFF = 2'b11
  } cbs_infmt_e;
  typedef enum logic [1:0] {
    DRV_PECL = 2'b00,
    DRV_LVDS = 2'b01,
    DRV_CMOS = 2'b10,
    DRV_OFF = 2'b11
  } cbs_drv_e;
  typedef enum logic [1:0] {
    PIN_ACTIVE = 2'b00,
    PIN_HIZ = 2'b01,
    PIN_INVERT = 2'b10,
    PIN_LOW = 2'b11
  } cbs_pin_e;
endpackage

// File: hdl/cbs_ch_if.sv
// one channel configuration word and its decoded settings
`timescale 1ns/100ps
interface cbs_ch_if;
  logic [27:0] cfg;
  logic [1:0] src_sel;
  cbs_pkg::cbs_drv_e drv;
  cbs_pkg::cbs_pin_e pos_mode;
  cbs_pkg::cbs_pin_e neg_mode;
  modport ctrl (output cfg, input src_sel, drv, pos_mode, neg_mode);
  modport dec (input cfg, output src_sel, drv, pos_mode, neg_mode);
endinterface

// File: hdl/cbs_chan_dec.sv
// decode of one output channel configuration word
`timescale 1ns/100ps
`include "cbs_defs.svh"
module cbs_chan_dec (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // channel word and decoded settings
  cbs_ch_if.dec ch
);
  logic [1:0] next_src_sel;
  cbs_pkg::cbs_drv_e next_drv;
  cbs_pkg::cbs_pin_e next_pos_mode;
  cbs_pkg::cbs_pin_e next_neg_mode;
  logic [5:0] drv_bits;

  always_comb
  begin
    drv_bits = {ch.cfg[`CBS_CH_DRV_LSB], ch.cfg[`CBS_CH_DRV_LSB + 1],
                ch.cfg[`CBS_CH_DRV_LSB + 2], ch.cfg[`CBS_CH_DRV_LSB + 3],
                ch.cfg[`CBS_CH_DRV_LSB + 4], ch.cfg[`CBS_CH_DRV_LSB + 5]};
    next_src_sel = {ch.cfg[`CBS_CH_SRC_X], ch.cfg[`CBS_CH_SRC_Y]};
    next_pos_mode = cbs_pkg::cbs_pin_e'({drv_bits[5], drv_bits[4]});
    next_neg_mode = cbs_pkg::cbs_pin_e'({drv_bits[3], drv_bits[2]});
    if (drv_bits[1:0] == 2'h0)
      next_drv = cbs_pkg::DRV_CMOS;
    else if (drv_bits == 6'h01)
      next_drv = cbs_pkg::DRV_PECL;
    else if (drv_bits == 6'h17)
      next_drv = cbs_pkg::DRV_LVDS;
    else
      next_drv = cbs_pkg::DRV_OFF;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ch.src_sel <= 2'h0;
      ch.drv <= cbs_pkg::DRV_OFF;
      ch.pos_mode <= cbs_pkg::PIN_HIZ;
      ch.neg_mode <= cbs_pkg::PIN_HIZ;
    end
    else
    begin
      ch.src_sel <= next_src_sel;
      ch.drv <= next_drv;
      ch.pos_mode <= next_pos_mode;
      ch.neg_mode <= next_neg_mode;
    end
  end
endmodule

// File: hdl/cbs_state_ctrl.sv
// device state control, register file and configuration decode
// Contract
// - control bit 7 low puts device to sleep, high runs normally.
// - control bit 8 low or alignment pin low enters alignment; both high leave.
// - at power-on the stored configuration is copied into working registers.
// - power-on ends after delays or shutdown low; port, dividers, drivers off.
// - alignment exit enters active; alignment, shutdown, sleep, recalibration leave.
// - shutdown low halts dividers and drivers; release resets and reloads.
// - sleep acts as shutdown but exit does not reload stored configuration.
// - alignment holds dividers and drivers off, then releases all together.
// - any channel register write runs an alignment sequence automatically.
// - input format from bits 5.1/5.0; hysteresis bit off turns inputs off.
// - failsafe bit enables LVDS idle guard on all inputs, DC only.
// - channel source from n.4/n.5: primary, secondary, auxiliary, reserved.
// - driver type from bits n.22 to n.27 per channel register.
// - single-ended mode drives two pins, each with its own mode.
// - five identical channels fed from three input clocks.
// - pin mode 00 active, 10 inverting, 11 low, 01 high impedance.
// - serial word holds four address bits first, then register content.
`timescale 1ns/100ps
`include "cbs_defs.svh"
module cbs_state_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control pins
  input wire logic shutdown_n,
  input wire logic align_n,
  input wire logic recal_req,
  input wire logic serial_latch_enable,
  // serial register words
  input wire logic word_valid,
  input wire logic [31:0] word_in,
  input wire logic [3:0] rd_addr,
  output logic [31:0] rd_data,
  // stored configuration
  output logic [3:0] nv_addr,
  input wire logic [27:0] nv_data,
  output logic nv_load_fault,
  // state and status
  output cbs_pkg::cbs_state_e state,
  output logic serial_port_on,
  output logic dividers_on,
  output logic drivers_on,
  output logic divider_release,
  // input receivers
  output cbs_pkg::cbs_infmt_e pri_format,
  output cbs_pkg::cbs_infmt_e sec_format,
  output logic pri_failsafe,
  output logic sec_failsafe,
  // channels
  input wire logic [2:0] src_clk_bus,
  output logic [9:0] ch_src_sel,
  output logic [9:0] ch_drv,
  output logic [9:0] ch_pos_mode,
  output logic [9:0] ch_neg_mode,
  output logic [4:0] ch_clk
);
  logic [27:0] cfg_mem [0:7];
  logic ctrl_sleep, ctrl_sync, sync_pending, shutdown_q;
  logic [7:0] cnt;
  cbs_pkg::cbs_state_e next_state;
  logic [7:0] next_cnt;
  logic next_sleep, next_sync, next_pending, next_fault;
  logic [3:0] next_nv_addr;
  logic wr_cfg, wr_any, ch_write, align_req;
  logic [3:0] wr_idx;
  logic [27:0] wr_data, rd_content, in_cfg;
  logic [31:0] next_rd_data;

  ////////////////////////////////////////////////////////////////////////////
  // state machine
  always_comb
  begin
    wr_any = word_valid && serial_port_on;
    ch_write = wr_any && (word_in[3:0] <= `CBS_ADDR_LAST_CH);
    align_req = !ctrl_sync || !align_n || sync_pending;
    next_state = state;
    next_cnt = cnt;
    next_sleep = ctrl_sleep;
    next_sync = ctrl_sync;
    next_pending = sync_pending || ch_write;
    next_nv_addr = nv_addr;
    next_fault = nv_load_fault;
    wr_cfg = 1'b0;
    wr_idx = word_in[3:0];
    wr_data = word_in[31:4];
    divider_release = 1'b0;
    if (wr_any && word_in[3:0] == `CBS_ADDR_CTRL)
    begin
      next_sleep = word_in[`CBS_CTRL_SLEEP + 4];
      next_sync = word_in[`CBS_CTRL_SYNC + 4];
    end
    else if (wr_any && word_in[3:0] < 4'(`CBS_NV_WORDS))
      wr_cfg = 1'b1;
    case (state)
      cbs_pkg::ST_POR:
      begin
        wr_cfg = 1'b0;
        if (!shutdown_n)
          next_state = cbs_pkg::ST_PDOWN;
        else if (cnt == 8'(`CBS_POR_CYCLES - 1))
        begin
          next_state = cbs_pkg::ST_LOAD;
          next_nv_addr = 4'h0;
        end
        else
          next_cnt = cnt + 8'h01;
      end
      cbs_pkg::ST_LOAD:
      begin
        wr_cfg = 1'b1;
        wr_idx = nv_addr;
        wr_data = nv_data;
        if (!shutdown_n)
          next_state = cbs_pkg::ST_PDOWN;
        else if (nv_addr == 4'(`CBS_NV_WORDS - 1))
        begin
          next_state = cbs_pkg::ST_SYNC;
          next_cnt = 8'h00;
        end
        else
          next_nv_addr = nv_addr + 4'h1;
      end
      cbs_pkg::ST_SYNC:
      begin
        if (ch_write)
          next_cnt = 8'h00;
        else if (cnt != 8'(`CBS_SYNC_CYCLES))
          next_cnt = cnt + 8'h01;
        if (!shutdown_n)
          next_state = cbs_pkg::ST_PDOWN;
        else if (!ctrl_sleep)
          next_state = cbs_pkg::ST_SLEEP;
        else if (sync_pending && cnt == 8'(`CBS_SYNC_CYCLES))
          next_pending = ch_write;
        else if (ctrl_sync && align_n && !sync_pending && !ch_write)
        begin
          next_state = cbs_pkg::ST_ACTIVE;
          divider_release = 1'b1;
        end
      end
      cbs_pkg::ST_ACTIVE:
      begin
        if (!shutdown_n)
          next_state = cbs_pkg::ST_PDOWN;
        else if (!ctrl_sleep)
          next_state = cbs_pkg::ST_SLEEP;
        else if (align_req || recal_req || ch_write)
        begin
          next_state = cbs_pkg::ST_SYNC;
          next_cnt = 8'h00;
        end
      end
      cbs_pkg::ST_PDOWN:
      begin
        if (shutdown_n)
        begin
          next_state = cbs_pkg::ST_POR;
          next_cnt = 8'h00;
          next_sleep = 1'b1;
          next_sync = 1'b1;
          next_pending = 1'b0;
          next_fault = !serial_latch_enable;
        end
      end
      cbs_pkg::ST_SLEEP:
      begin
        if (!shutdown_n)
          next_state = cbs_pkg::ST_PDOWN;
        else if (ctrl_sleep)
        begin
          next_state = cbs_pkg::ST_SYNC;
          next_cnt = 8'h00;
        end
      end
      default:
        next_state = cbs_pkg::ST_POR;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state <= cbs_pkg::ST_POR;
      cnt <= 8'h00;
      ctrl_sleep <= 1'b1;
      ctrl_sync <= 1'b1;
      sync_pending <= 1'b0;
      nv_addr <= 4'h0;
      nv_load_fault <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      ctrl_sleep <= next_sleep;
      ctrl_sync <= next_sync;
      sync_pending <= next_pending;
      nv_addr <= next_nv_addr;
      nv_load_fault <= next_fault;
    end
  end

  always_ff @(posedge clk)
  begin
    if (wr_cfg)
      cfg_mem[wr_idx[2:0]] <= wr_data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // status and register read
  always_comb
  begin
    serial_port_on = (state != cbs_pkg::ST_POR) && (state != cbs_pkg::ST_LOAD);
    dividers_on = (state == cbs_pkg::ST_ACTIVE);
    drivers_on = (state == cbs_pkg::ST_ACTIVE);
    rd_content = 28'h0;
    if (rd_addr < 4'(`CBS_NV_WORDS))
      rd_content = cfg_mem[rd_addr[2:0]];
    else if (rd_addr == `CBS_ADDR_CTRL)
    begin
      rd_content[`CBS_CTRL_SLEEP] = ctrl_sleep;
      rd_content[`CBS_CTRL_SYNC] = ctrl_sync;
      rd_content[`CBS_CTRL_REV_LSB +: 3] = `CBS_REV_VALUE;
    end
    next_rd_data = {rd_content, rd_addr};
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rd_data <= 32'h0;
    else
      rd_data <= next_rd_data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // input receivers
  function automatic cbs_pkg::cbs_infmt_e fmt_of(input logic [27:0] c);
    if (!c[`CBS_IN_HYST])
      return cbs_pkg::IN_OFF;
    case ({c[`CBS_IN_FMT_X], c[`CBS_IN_FMT_Y]})
      2'b00: return cbs_pkg::IN_CMOS;
      2'b10: return cbs_pkg::IN_PECL;
      2'b11: return cbs_pkg::IN_LVDS;
      default: return cbs_pkg::IN_OFF;
    endcase
  endfunction

  always_comb
  begin
    in_cfg = cfg_mem[3'(`CBS_ADDR_INPUT)];
    pri_format = fmt_of(in_cfg);
    sec_format = pri_format;
    pri_failsafe = in_cfg[`CBS_IN_FAILSAFE] && in_cfg[`CBS_IN_DC] &&
                   (pri_format == cbs_pkg::IN_LVDS);
    sec_failsafe = pri_failsafe;
  end

  ////////////////////////////////////////////////////////////////////////////
  // output channels
  for (genvar g = 0; g < `CBS_NUM_CH; g++)
  begin : g_ch
    cbs_ch_if ch_bus ();
    assign ch_bus.cfg = cfg_mem[g];
    cbs_chan_dec u_dec (
      .clk(clk),
      .sys_rst(sys_rst),
      .ch(ch_bus)
    );
    assign ch_src_sel[2*g +: 2] = ch_bus.src_sel;
    assign ch_drv[2*g +: 2] = ch_bus.drv;
    assign ch_pos_mode[2*g +: 2] = ch_bus.pos_mode;
    assign ch_neg_mode[2*g +: 2] = ch_bus.neg_mode;
    assign ch_clk[g] = dividers_on && (ch_bus.src_sel != 2'h3) &&
                       src_clk_bus[ch_bus.src_sel];
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_sync_exit;
    state == cbs_pkg::ST_SYNC && divider_release;
  endsequence
  property p_por_quiet;
    @(posedge clk) disable iff (sys_rst)
    (state == cbs_pkg::ST_POR || state == cbs_pkg::ST_LOAD)
      |-> !serial_port_on && !dividers_on && !drivers_on;
  endproperty
  a_por_quiet: assert property (p_por_quiet) else $error("port or outputs on at power-on");
  property p_sleep_enter;
    @(posedge clk) disable iff (sys_rst)
    (state == cbs_pkg::ST_ACTIVE && shutdown_n && !ctrl_sleep)
      |=> state == cbs_pkg::ST_SLEEP;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");
  property p_align_enter;
    @(posedge clk) disable iff (sys_rst)
    (state == cbs_pkg::ST_ACTIVE && shutdown_n && ctrl_sleep && (!align_n || !ctrl_sync))
      |=> state == cbs_pkg::ST_SYNC;
  endproperty
  a_align_enter: assert property (p_align_enter) else $error("alignment not entered");
  property p_pdown;
    @(posedge clk) disable iff (sys_rst)
    (!shutdown_n && state != cbs_pkg::ST_PDOWN)
      |=> state == cbs_pkg::ST_PDOWN && serial_port_on && !drivers_on;
  endproperty
  a_pdown: assert property (p_pdown) else $error("shutdown not honoured");
  property p_pdown_exit;
    @(posedge clk) disable iff (sys_rst)
    (state == cbs_pkg::ST_PDOWN && shutdown_n)
      |=> state == cbs_pkg::ST_POR && cnt == 8'h00 && ctrl_sleep && ctrl_sync;
  endproperty
  a_pdown_exit: assert property (p_pdown_exit) else $error("no reload after shutdown");
  property p_por_load;
    @(posedge clk) disable iff (sys_rst)
    (state == cbs_pkg::ST_POR && shutdown_n && cnt == 8'(`CBS_POR_CYCLES - 1))
      |=> state == cbs_pkg::ST_LOAD && nv_addr == 4'h0;
  endproperty
  a_por_load: assert property (p_por_load) else $error("stored load not started");
  property p_sleep_exit;
    @(posedge clk) disable iff (sys_rst)
    (state == cbs_pkg::ST_SLEEP && shutdown_n && ctrl_sleep)
      |=> state == cbs_pkg::ST_SYNC;
  endproperty
  a_sleep_exit: assert property (p_sleep_exit) else $error("sleep exit went wrong");
  property p_sync_release;
    @(posedge clk) disable iff (sys_rst)
    s_sync_exit |=> state == cbs_pkg::ST_ACTIVE && dividers_on && drivers_on;
  endproperty
  a_sync_release: assert property (p_sync_release) else $error("dividers not released");
  property p_auto_sync;
    @(posedge clk) disable iff (sys_rst)
    (state == cbs_pkg::ST_ACTIVE && shutdown_n && ctrl_sleep && ch_write)
      |=> state == cbs_pkg::ST_SYNC ##1 !dividers_on [*8];
  endproperty
  a_auto_sync: assert property (p_auto_sync) else $error("no alignment after write");
  property p_rev_ro;
    @(posedge clk) disable iff (sys_rst)
    (rd_addr == `CBS_ADDR_CTRL) |=> rd_data[16:14] == `CBS_REV_VALUE;
  endproperty
  a_rev_ro: assert property (p_rev_ro) else $error("revision bits changed");
endmodule

// File: verif/cbs_host_model.sv
// serial host and stored configuration model facing the state control
`timescale 1ns/100ps
module cbs_host_model (
  // clock
  input wire logic clk,
  // serial words and read-back
  output logic word_valid,
  output logic [31:0] word_in,
  output logic [3:0] rd_addr,
  input wire logic [31:0] rd_data,
  output logic serial_latch_enable,
  // stored configuration
  input wire logic [3:0] nv_addr,
  output logic [27:0] nv_data
);
  logic [27:0] nv_mem [0:7];
  ////////////////////////////////////////////////////////////////////////////////
  // stored word in the same cycle; outside the array the data toggles with the address
  always_comb nv_data = nv_addr[3] ? {14{nv_addr[0], ~nv_addr[0]}} : nv_mem[nv_addr[2:0]];
  initial
  begin
    word_valid = 1'h0;
    word_in = 32'h0;
    rd_addr = 4'h0;
    serial_latch_enable = 1'h1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one word per strobe, address nibble low; bus inverted once released
  task automatic send(input logic [3:0] addr, input logic [27:0] content);
    @(posedge clk);
    word_valid <= 1'h1;
    word_in <= {content, addr};
    @(posedge clk);
    word_valid <= 1'h0;
    word_in <= ~{content, addr};
  endtask
  task automatic fetch(input logic [3:0] addr, output logic [31:0] data);
    @(posedge clk);
    rd_addr <= addr;
    @(posedge clk);
    @(posedge clk);
    #1 data = rd_data;
  endtask
  // latch enable level seen at the shutdown release
  task automatic latch(input logic v);
    @(posedge clk);
    serial_latch_enable <= v;
  endtask
endmodule

// File: verif/clock_buffer_state_config_tb.sv
// self-checking bench for the clock buffer state control
`timescale 1ns/100ps
`include "cbs_defs.svh"
module clock_buffer_state_config_tb;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic shutdown_n = 1'h1;
  logic align_n = 1'h1;
  logic recal_req = 1'h0;
  logic [2:0] src_clk_bus = 3'h1;
  logic word_valid, serial_latch_enable, nv_load_fault, serial_port_on, dividers_on;
  logic drivers_on, divider_release, pri_failsafe, sec_failsafe, rel;
  logic [31:0] word_in, rd_data, rd;
  logic [3:0] rd_addr, nv_addr;
  logic [27:0] nv_data, nw0;
  logic [27:0] nvw [0:7];
  logic [9:0] ch_src_sel, ch_drv, ch_pos_mode, ch_neg_mode;
  logic [4:0] ch_clk;
  cbs_pkg::cbs_state_e state;
  cbs_pkg::cbs_infmt_e pri_format, sec_format;
  int miscompares = 0;
  int check_count = 0;
  localparam logic [5:0] DRV_F [0:4] = '{6'h20, 6'h3A, 6'h1A, 6'h0D, 6'h02};
  localparam logic [1:0] SRC [0:4] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
  localparam cbs_pkg::cbs_drv_e EXP_DRV [0:4] = '{cbs_pkg::DRV_PECL, cbs_pkg::DRV_LVDS,
    cbs_pkg::DRV_OFF, cbs_pkg::DRV_CMOS, cbs_pkg::DRV_CMOS};
  localparam logic [27:0] IN_W [0:4] = '{28'h80, 28'h82, 28'hC3, 28'h8C3, 28'h43};
  localparam cbs_pkg::cbs_infmt_e IN_E [0:4] = '{cbs_pkg::IN_CMOS, cbs_pkg::IN_PECL,
    cbs_pkg::IN_LVDS, cbs_pkg::IN_LVDS, cbs_pkg::IN_OFF};
  localparam logic [27:0] REV_BITS = 28'(`CBS_REV_VALUE) << 10;
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  cbs_host_model u_host (.clk(clk), .word_valid(word_valid), .word_in(word_in),
    .rd_addr(rd_addr), .rd_data(rd_data), .serial_latch_enable(serial_latch_enable),
    .nv_addr(nv_addr), .nv_data(nv_data));
  cbs_state_ctrl dut (.clk(clk), .sys_rst(sys_rst), .shutdown_n(shutdown_n),
    .align_n(align_n), .recal_req(recal_req), .serial_latch_enable(serial_latch_enable),
    .word_valid(word_valid), .word_in(word_in), .rd_addr(rd_addr), .rd_data(rd_data),
    .nv_addr(nv_addr), .nv_data(nv_data), .nv_load_fault(nv_load_fault), .state(state),
    .serial_port_on(serial_port_on), .dividers_on(dividers_on), .drivers_on(drivers_on),
    .divider_release(divider_release), .pri_format(pri_format), .sec_format(sec_format),
    .pri_failsafe(pri_failsafe), .sec_failsafe(sec_failsafe), .src_clk_bus(src_clk_bus),
    .ch_src_sel(ch_src_sel), .ch_drv(ch_drv), .ch_pos_mode(ch_pos_mode),
    .ch_neg_mode(ch_neg_mode), .ch_clk(ch_clk));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_st(input cbs_pkg::cbs_state_e st, input int lim);
    int n;
    n = 0;
    #1;
    while (state !== st && n < lim)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk("state", 32'(st), 32'(state));
  endtask
  task automatic off_chk(input logic port_on);
    chk("serial_port_on", 32'(port_on), 32'(serial_port_on));
    chk("dividers_on", 32'h0, 32'(dividers_on));
    chk("drivers_on", 32'h0, 32'(drivers_on));
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #60000;
    miscompares++;
    report_and_stop;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    for (int g = 0; g < 5; g++)
      nvw[g] = {DRV_F[g], 16'h0, SRC[g][0], SRC[g][1], 4'h0};
    nvw[5] = 28'h8C3;
    nvw[6] = 28'h0;
    nvw[7] = 28'h0;
    for (int g = 0; g < 8; g++)
      u_host.nv_mem[g] = nvw[g];
    nw0 = {6'h20, 16'h0, 1'h0, 1'h1, 4'h0};
    repeat (3) @(posedge clk);
    sys_rst <= 1'h0;
    #1 chk("state", 32'(cbs_pkg::ST_POR), 32'(state));
    off_chk(1'h0);
    u_host.send(4'h8, 28'h0);
    wait_st(cbs_pkg::ST_ACTIVE, 200);
    u_host.fetch(4'h0, rd);
    chk("reg0", {nvw[0], 4'h0}, rd);
    chk("pri_format", 32'(cbs_pkg::IN_LVDS), 32'(pri_format));
    chk("pri_failsafe", 32'h1, 32'(pri_failsafe));
    for (int g = 0; g < 5; g++)
    begin
      chk("ch_drv", 32'(EXP_DRV[g]), 32'(ch_drv[2*g+:2]));
      chk("ch_src_sel", 32'(SRC[g]), 32'(ch_src_sel[2*g+:2]));
      for (int p = 0; p < 3; p++)
      begin
        @(posedge clk);
        src_clk_bus <= 3'(1 << p);
        cyc(1);
        chk("ch_clk", 32'(SRC[g] == 2'h3 ? 1'h0 : SRC[g] == p), 32'(ch_clk[g]));
      end
    end
    chk("pos3", 32'(cbs_pkg::PIN_INVERT), 32'(ch_pos_mode[7:6]));
    chk("neg3", 32'(cbs_pkg::PIN_LOW), 32'(ch_neg_mode[7:6]));
    chk("pos4", 32'(cbs_pkg::PIN_HIZ), 32'(ch_pos_mode[9:8]));
    chk("neg4", 32'(cbs_pkg::PIN_ACTIVE), 32'(ch_neg_mode[9:8]));
    for (int k = 0; k < 5; k++)
    begin
      u_host.send(4'h5, IN_W[k]);
      cyc(2);
      chk("pri_format", 32'(IN_E[k]), 32'(pri_format));
      chk("sec_format", 32'(IN_E[k]), 32'(sec_format));
      chk("pri_failsafe", 32'(k == 3), 32'(pri_failsafe));
      chk("sec_failsafe", 32'(k == 3), 32'(sec_failsafe));
    end
    wait_st(cbs_pkg::ST_ACTIVE, 40);
    u_host.send(4'h0, nw0);
    cyc(1);
    chk("state", 32'(cbs_pkg::ST_SYNC), 32'(state));
    off_chk(1'h1);
    cyc(5);
    chk("state", 32'(cbs_pkg::ST_SYNC), 32'(state));
    wait_st(cbs_pkg::ST_ACTIVE, 40);
    chk("ch_clk aux", 32'h1, 32'(ch_clk[0]));
    u_host.send(4'h9, 28'h0);
    u_host.send(4'h8, 28'h100);
    wait_st(cbs_pkg::ST_SLEEP, 3);
    off_chk(1'h1);
    chk("ch_clk", 32'h0, 32'(ch_clk));
    u_host.send(4'h8, 28'h1D80);
    wait_st(cbs_pkg::ST_ACTIVE, 40);
    u_host.fetch(4'h0, rd);
    chk("reg0", {nw0, 4'h0}, rd);
    u_host.fetch(4'h8, rd);
    chk("reg8", {28'h180 | REV_BITS, 4'h8}, rd);
    @(posedge clk);
    align_n <= 1'h0;
    wait_st(cbs_pkg::ST_SYNC, 3);
    off_chk(1'h1);
    cyc(3);
    chk("state", 32'(cbs_pkg::ST_SYNC), 32'(state));
    align_n <= 1'h1;
    rel = 1'h0;
    repeat (30)
    begin
      #1 rel = rel | (divider_release === 1'h1);
      @(posedge clk);
    end
    chk("divider_release", 32'h1, 32'(rel));
    chk("state", 32'(cbs_pkg::ST_ACTIVE), 32'(state));
    u_host.send(4'h8, 28'h080);
    wait_st(cbs_pkg::ST_SYNC, 3);
    cyc(15);
    chk("state", 32'(cbs_pkg::ST_SYNC), 32'(state));
    u_host.send(4'h8, 28'h180);
    wait_st(cbs_pkg::ST_ACTIVE, 20);
    @(posedge clk);
    recal_req <= 1'h1;
    cyc(3);
    chk("left active", 32'h1, 32'(state !== cbs_pkg::ST_ACTIVE));
    recal_req <= 1'h0;
    @(posedge clk);
    shutdown_n <= 1'h0;
    wait_st(cbs_pkg::ST_PDOWN, 3);
    off_chk(1'h1);
    @(posedge clk);
    shutdown_n <= 1'h1;
    wait_st(cbs_pkg::ST_ACTIVE, 200);
    u_host.fetch(4'h0, rd);
    chk("reg0", {nvw[0], 4'h0}, rd);
    chk("nv_load_fault", 32'h0, 32'(nv_load_fault));
    @(posedge clk);
    shutdown_n <= 1'h0;
    u_host.latch(1'h0);
    cyc(2);
    shutdown_n <= 1'h1;
    cyc(5);
    chk("nv_load_fault", 32'h1, 32'(nv_load_fault));
    chk("state", 32'(cbs_pkg::ST_POR), 32'(state));
    shutdown_n <= 1'h0;
    wait_st(cbs_pkg::ST_PDOWN, 3);
    u_host.latch(1'h1);
    @(posedge clk);
    shutdown_n <= 1'h1;
    wait_st(cbs_pkg::ST_ACTIVE, 200);
    report_and_stop;
  end
endmodule
